// >>> hdl/sts_defs.svh
// Constants for the serial transfer sequencer
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH
`define STS_CHAR_W 24
`define STS_LEN_W 5
`define STS_LC_BIT 29
`define STS_ST_BIT 28
`define STS_GAP_CYC 3
`define STS_LEAD_HALVES_CDE0 1
`define STS_LEAD_HALVES_CDE1 2
`define STS_TRAIL_HALVES_CDE0 2
`define STS_TRAIL_HALVES_CDE1 1
`define STS_LEN_RESET 24
`define STS_HALF_DIV 4
`endif

// >>> hdl/sts_pkg.sv
// Types and helpers shared by the serial transfer sequencer
`include "sts_defs.svh"
package sts_pkg;
    typedef enum logic [5:0] {
        st_idle  = 6'h01,
        st_lead  = 6'h02,
        st_shift = 6'h04,
        st_trail = 6'h08,
        st_gap   = 6'h10,
        st_done  = 6'h20
    } sts_state_e;

    function automatic logic [23:0] sts_mask(input logic [4:0] len);
        return ~(24'hffffff << len);
    endfunction

    function automatic logic sts_msb(input logic [23:0] w,
                                     input logic [4:0] len);
        return w[len - 5'h01];
    endfunction
endpackage

// >>> hdl/sts_link_shift.sv
// Slave shifter running on the received serial clock
`timescale 1ns/1ps
`include "sts_defs.svh"
module sts_link_shift (
    input logic link_clk,
    input logic sys_rst,
    input logic slave_select_n,
    input logic mosi,
    input logic [23:0] tx_word,
    input logic [4:0] tx_len,
    input logic tx_tog,
    output logic ack_tog,
    output logic [23:0] rx_word,
    output logic rx_tog,
    output logic uf_tog,
    output logic miso
);
    typedef struct packed {
        logic [1:0] tog_s;
        logic ack;
        logic [4:0] len;
        logic [23:0] sh;
        logic [4:0] cnt;
        logic [23:0] rxw;
        logic rxt;
        logic uft;
        logic miso;
    } sts_link_s;

    localparam sts_link_s LINK_RST = '{len: 5'(`STS_LEN_RESET), default: '0};

    sts_link_s q;
    sts_link_s n;
    logic frame_q;
    logic frame_rst;
    logic [4:0] cnt_use;
    logic [4:0] ln;
    logic [23:0] src;
    logic tog_now;

    // The clock stops between frames, so the frame start is caught by
    // an asynchronous clear from the select line instead of an edge.
    assign frame_rst = sys_rst | slave_select_n;

    always_ff @(posedge link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            frame_q <= 1'b0;
        end else begin
            frame_q <= 1'b1;
        end
    end

    always_comb begin
        n = q;
        // The clock stands still between frames, so the synchroniser is
        // stale at a frame's first edge; the hold word has stood since idle
        tog_now = frame_q ? q.tog_s[1] : tx_tog;
        n.tog_s = frame_q ? {q.tog_s[0], tx_tog} : {tx_tog, tx_tog};
        cnt_use = frame_q ? q.cnt : 5'h00;
        src = q.sh;
        ln = q.len;
        if (cnt_use == 5'h00) begin
            if (tog_now != q.ack) begin
                src = tx_word;
                ln = tx_len;
                n.ack = ~q.ack;
            end else begin
                src = 24'h000000;
                n.uft = ~q.uft;
            end
            n.len = ln;
        end
        // Shift out and in on the same edge
        n.miso = sts_pkg::sts_msb(src, ln);
        n.sh = {src[22:0], mosi};
        if (cnt_use == ln - 5'h01) begin
            n.cnt = 5'h00;
            n.rxw = n.sh & sts_pkg::sts_mask(ln);
            n.rxt = ~q.rxt;
        end else begin
            n.cnt = cnt_use + 5'h01;
        end
    end

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= LINK_RST;
        end else begin
            q <= n;
        end
    end

    assign ack_tog = q.ack;
    assign rx_word = q.rxw;
    assign rx_tog = q.rxt;
    assign uf_tog = q.uft;
    assign miso = q.miso;

    uf_zero_out_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        (cnt_use == 5'h00 && tog_now == q.ack) |=> !q.miso)
        else $error("underflow character not sent as zeros");

    cover_link_char_c: cover property (@(posedge link_clk)
        disable iff (sys_rst) $changed(q.rxt));
endmodule

// >>> hdl/sts_transfer_seq.sv
// Serial peripheral transfer sequencer, master and slave
`timescale 1ns/1ps
`include "sts_defs.svh"
module sts_transfer_seq #(
    parameter int HALF_DIV = `STS_HALF_DIV
) (
    input logic core_clk,
    input logic sys_rst,
    input logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n,
    input logic data_out_pin_i,
    output logic data_out_pin_o,
    output logic data_out_pin_oe_n,
    input logic data_in_pin_i,
    output logic data_in_pin_o,
    output logic data_in_pin_oe_n,
    input logic slave_select_n_i,
    output logic slave_select_n_o,
    input logic slave_mode,
    input logic dma_disable,
    input logic clock_delay_enable,
    input logic [4:0] char_len,
    input logic rx_overflow_mask,
    input logic tx_underflow_mask,
    input logic master_start_cmd,
    input logic error_clear,
    input logic [31:0] tx_word,
    input logic tx_valid,
    input logic tx_desc_end,
    output logic tx_pop,
    output logic [23:0] rx_data,
    output logic rx_valid,
    input logic rx_ready,
    input logic rx_fifo_empty,
    output logic rx_desc_close,
    output logic master_done_event,
    output logic master_busy,
    output logic multi_master_error,
    output logic tx_underflow_event,
    output logic rx_overflow_event,
    output logic halted
);
    if (HALF_DIV < 3 || HALF_DIV > 255) begin : g_bad_div
        $error("HALF_DIV must lie in 3..255");
    end

    typedef struct packed {
        sts_pkg::sts_state_e st;
        logic [7:0] div;
        logic [5:0] half;
        logic [23:0] sh;
        logic lc;
        logic tg;
        logic de;
        logic sclk;
        logic mosi;
        logic ss_n;
        logic smode;
        logic smode_n;
        logic [1:0] miso_s;
        logic [1:0] ssi_s;
        logic ssi_p;
        logic [1:0] ack_s;
        logic [2:0] rxt_s;
        logic [2:0] uft_s;
        logic stog;
        logic [23:0] hold;
        logic [4:0] hlen;
        logic [23:0] rxd;
        logic rxv;
        logic pop;
        logic done;
        logic ufe;
        logic roe;
        logic close;
        logic busy;
        logic mm;
        logic halt;
    } sts_core_s;

    localparam sts_core_s CORE_RST = '{st: sts_pkg::st_idle, ss_n: 1'b1,
        ssi_s: 2'b11, ssi_p: 1'b1, smode_n: 1'b1,
        hlen: 5'(`STS_LEN_RESET), default: '0};

    sts_core_s q;
    sts_core_s n;
    logic tick;
    logic dma;
    logic err;
    logic mm_now;
    logic done_x;
    logic [5:0] lead_h;
    logic [5:0] trail_h;
    logic [5:0] two_len;
    logic [23:0] sh_new;
    logic ack_tog;
    logic rx_tog;
    logic uf_tog;
    logic [23:0] link_rx;

    function automatic sts_core_s fetch_char(input sts_core_s s,
        input logic vld, input logic [31:0] w, input logic dend,
        input logic [4:0] len);
        sts_core_s r;
        r = s;
        r.pop = vld;
        r.ufe = ~vld;
        r.sh = vld ? (w[23:0] & sts_pkg::sts_mask(len)) : 24'h000000;
        r.lc = vld & w[`STS_LC_BIT];
        r.tg = vld & w[`STS_ST_BIT];
        r.de = vld & dend;
        r.mosi = sts_pkg::sts_msb(r.sh, len);
        return r;
    endfunction

    assign tick = (q.div == 8'(HALF_DIV - 1));
    assign dma = ~dma_disable;
    assign lead_h = clock_delay_enable ? 6'(`STS_LEAD_HALVES_CDE1)
                                       : 6'(`STS_LEAD_HALVES_CDE0);
    assign trail_h = clock_delay_enable ? 6'(`STS_TRAIL_HALVES_CDE1)
                                        : 6'(`STS_TRAIL_HALVES_CDE0);
    assign two_len = 6'({1'b0, char_len} << 1);
    assign sh_new = {q.sh[22:0], q.miso_s[1]};

    always_comb begin
        n = q;
        n.pop = 1'b0;
        n.rxv = 1'b0;
        n.done = 1'b0;
        n.ufe = 1'b0;
        n.roe = 1'b0;
        n.close = 1'b0;
        done_x = 1'b0;
        n.miso_s = {q.miso_s[0], data_in_pin_i};
        n.ssi_s = {q.ssi_s[0], slave_select_n_i};
        n.ssi_p = q.ssi_s[1];
        n.ack_s = {q.ack_s[0], ack_tog};
        n.rxt_s = {q.rxt_s[1:0], rx_tog};
        n.uft_s = {q.uft_s[1:0], uf_tog};
        n.smode = slave_mode;
        n.smode_n = ~slave_mode;
        n.div = tick ? 8'h00 : q.div + 8'h01;
        unique case (q.st)
            sts_pkg::st_idle: begin
                n.sclk = 1'b0;
                n.ss_n = 1'b1;
                if (master_start_cmd && !slave_mode && !q.halt) begin
                    n = fetch_char(n, tx_valid, tx_word, tx_desc_end,
                                   char_len);
                    n.st = sts_pkg::st_lead;
                    n.ss_n = 1'b0;
                    n.div = 8'h00;
                    n.half = lead_h;
                end
            end
            sts_pkg::st_lead: begin
                if (tick) begin
                    n.half = q.half - 6'h01;
                    if (q.half == 6'h01) begin
                        n.sclk = 1'b1;
                        n.half = two_len - 6'h01;
                        n.st = sts_pkg::st_shift;
                    end
                end
            end
            sts_pkg::st_shift: begin
                if (tick) begin
                    n.sclk = ~q.sclk;
                    n.half = q.half - 6'h01;
                    if (q.sclk && q.half == 6'h01) begin
                        n.rxv = 1'b1;
                        n.rxd = sh_new & sts_pkg::sts_mask(char_len);
                        if ((dma ? q.de : q.lc) || q.tg) begin
                            n.st = sts_pkg::st_trail;
                            n.half = trail_h;
                        end else begin
                            n = fetch_char(n, tx_valid, tx_word,
                                           tx_desc_end, char_len);
                            n.half = two_len;
                        end
                    end else if (q.sclk) begin
                        n.sh = sh_new;
                        n.mosi = sts_pkg::sts_msb(sh_new, char_len);
                    end
                end
            end
            sts_pkg::st_trail: begin
                if (tick) begin
                    n.half = q.half - 6'h01;
                    if (q.half == 6'h01) begin
                        n.ss_n = 1'b1;
                        done_x = dma ? (q.de & ~tx_valid) : q.lc;
                        if (done_x) begin
                            n.st = sts_pkg::st_done;
                        end else begin
                            n.st = sts_pkg::st_gap;
                            n.half = 6'(`STS_GAP_CYC);
                        end
                    end
                end
            end
            sts_pkg::st_gap: begin
                n.half = q.half - 6'h01;
                if (q.half == 6'h01) begin
                    n = fetch_char(n, tx_valid, tx_word, tx_desc_end,
                                   char_len);
                    n.st = sts_pkg::st_lead;
                    n.ss_n = 1'b0;
                    n.div = 8'h00;
                    n.half = lead_h;
                end
            end
            sts_pkg::st_done: begin
                if (!dma || rx_fifo_empty) begin
                    n.done = 1'b1;
                    n.st = sts_pkg::st_idle;
                end
            end
            default: begin
                n.st = sts_pkg::st_idle;
                n.ss_n = 1'b1;
            end
        endcase
        // Slave side: hold word waits for the link to take it
        if (q.smode && !q.halt && q.ack_s[1] == q.stog && tx_valid &&
            !q.pop) begin
            n.hold = tx_word[23:0] & sts_pkg::sts_mask(char_len);
            n.hlen = char_len;
            n.stog = ~q.stog;
            n.pop = 1'b1;
        end
        if (q.smode && !q.halt && (q.rxt_s[2] ^ q.rxt_s[1])) begin
            n.rxv = 1'b1;
            n.rxd = link_rx;
        end
        if (q.smode && (q.uft_s[2] ^ q.uft_s[1])) begin
            n.ufe = 1'b1;
        end
        // Only the rx side is closed; the rest of a part-sent tx word is dropped
        if (q.smode && q.ssi_s[1] && !q.ssi_p) begin
            n.close = 1'b1;
        end
        n.roe = n.rxv & ~rx_ready;
        mm_now = ~q.smode & ~q.ssi_s[1];
        n.mm = (q.mm & ~error_clear) | mm_now;
        err = (n.roe & ~rx_overflow_mask) | (n.ufe & ~tx_underflow_mask)
            | mm_now;
        n.halt = (q.halt & ~error_clear) | err;
        if (err) begin
            n.st = sts_pkg::st_idle;
            n.ss_n = 1'b1;
            n.sclk = 1'b0;
        end
        n.busy = (n.st != sts_pkg::st_idle);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= CORE_RST;
        end else begin
            q <= n;
        end
    end

    sts_link_shift u_link (
        .link_clk(serial_clock_pin_i),
        .sys_rst(sys_rst),
        .slave_select_n(slave_select_n_i),
        .mosi(data_out_pin_i),
        .tx_word(q.hold),
        .tx_len(q.hlen),
        .tx_tog(q.stog),
        .ack_tog(ack_tog),
        .rx_word(link_rx),
        .rx_tog(rx_tog),
        .uf_tog(uf_tog),
        .miso(data_in_pin_o)
    );

    assign serial_clock_pin_o = q.sclk;
    assign serial_clock_pin_oe_n = q.smode;
    assign data_out_pin_o = q.mosi;
    assign data_out_pin_oe_n = q.smode;
    assign data_in_pin_oe_n = q.smode_n;
    assign slave_select_n_o = q.ss_n;
    assign tx_pop = q.pop;
    assign rx_data = q.rxd;
    assign rx_valid = q.rxv;
    assign rx_desc_close = q.close;
    assign master_done_event = q.done;
    assign master_busy = q.busy;
    assign multi_master_error = q.mm;
    assign tx_underflow_event = q.ufe;
    assign rx_overflow_event = q.roe;
    assign halted = q.halt;

    // Checking aid: cycles spent in the current state
    logic [15:0] ph_cnt;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ph_cnt <= 16'h0000;
        end else if (n.st != q.st) begin
            ph_cnt <= 16'h0000;
        end else begin
            ph_cnt <= ph_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    lead_delay_a: assert property (
        (q.st == sts_pkg::st_lead && n.st == sts_pkg::st_shift)
        |-> ph_cnt == 16'(32'(lead_h) * HALF_DIV - 1) && !q.ss_n)
        else $error("select lead time wrong");
    trail_delay_a: assert property (
        (q.st == sts_pkg::st_trail && n.ss_n && !err)
        |-> ph_cnt == 16'(32'(trail_h) * HALF_DIV - 1))
        else $error("select trail time wrong");
    sel_gap_a: assert property (
        (q.st == sts_pkg::st_gap && $rose(q.ss_n))
        |-> q.ss_n [*3])
        else $error("select gap shorter than three cycles");
    halt_ovf_a: assert property (
        (n.roe && !rx_overflow_mask) |=> halted && !master_busy)
        else $error("unmasked overflow did not halt");
    mask_hold_a: assert property (
        (!q.halt && !error_clear && n.ufe && tx_underflow_mask && !n.roe
         && !mm_now) |=> !halted)
        else $error("masked underflow halted");
    done_dma_a: assert property (
        (q.st == sts_pkg::st_done && dma && !rx_fifo_empty && !err)
        |=> !master_done_event)
        else $error("done raised before rx FIFO empty");
    mm_flag_a: assert property (
        (!q.smode && !q.ssi_s[1]) |=> multi_master_error && halted)
        else $error("multi-master not flagged");
    pin_dir_a: assert property (
        ##1 serial_clock_pin_oe_n == $past(slave_mode)
        && data_in_pin_oe_n == !$past(slave_mode))
        else $error("pin direction does not follow mode");
    idle_sel_a: assert property (
        (q.st == sts_pkg::st_idle) |-> slave_select_n_o)
        else $error("select low while idle");
    rx_close_a: assert property (
        (q.smode && q.ssi_s[1] && !q.ssi_p) |=> rx_desc_close)
        else $error("rx descriptor not closed on select release");

    cover_done_c: cover property (master_done_event && !dma_disable);
    cover_toggle_c: cover property (q.st == sts_pkg::st_gap && !q.de);
    cover_slave_c: cover property (rx_desc_close && rx_valid);
endmodule

// >>> sim/sts_peer.sv
// Far-side model: serial slave to the master, or a foreign master
`timescale 1ns/1ps
module sts_peer (
    input wire logic sclk_o,
    input wire logic mosi_o,
    input wire logic sel_n_o,
    input wire logic miso_o,
    input wire logic [4:0] len,
    input wire logic [23:0] reply,
    output logic sclk_i,
    output logic mosi_i,
    output logic miso_i,
    output logic sel_n_i,
    output logic [23:0] got,
    output int nchar
);
    logic [23:0] sh = 24'h0;
    int nb = 0;
    initial begin
        sclk_i = 1'b0;
        mosi_i = 1'b1;
        miso_i = 1'b1;
        sel_n_i = 1'b1;
        got = 24'h0;
        nchar = 0;
    end
    // Lines are pulled up, so a released data line reads high
    always @(sel_n_o) begin
        nb = 0;
        miso_i = sel_n_o ? 1'b1 : reply[len - 5'h1];
    end
    // Take data on rising, answer after falling
    always @(posedge sclk_o) begin
        if (!sel_n_o) begin
            sh = {sh[22:0], mosi_o};
            nb++;
            if (nb == int'(len)) begin
                got = sh & ~(24'hffffff << len);
                nchar++;
                nb = 0;
            end
        end
    end
    always @(negedge sclk_o) begin
        if (!sel_n_o) begin
            #1 miso_i = reply[len - 5'h1 - 5'(nb)];
        end
    end
    // Second master; link clock stands low between frames
    task automatic frame(input logic [23:0] dv, output logic [23:0] qv);
        qv = 24'h0;
        sel_n_i = 1'b0;
        #160;
        for (int i = int'(len) - 1; i >= 0; i--) begin
            mosi_i = dv[i];
            #80 sclk_i = 1'b1;
            #80 sclk_i = 1'b0;
            qv = {qv[22:0], miso_o};
        end
        #1 mosi_i = 1'b1;
        #159 sel_n_i = 1'b1;
    endtask
endmodule

// >>> sim/sts_testbench.sv
// Self-checking bench for the serial transfer sequencer
`timescale 1ns/1ps
module testbench;
    localparam int H = 4;
    logic core_clk = 1'b0, sys_rst, slave_mode = 1'b0;
    logic dma_off = 1'b1, cde = 1'b0, ro_m = 1'b0, tu_m = 1'b0;
    logic start = 1'b0, clr = 1'b0, rx_ready = 1'b1, rx_empty = 1'b1;
    logic tx_valid = 1'b0, tx_end = 1'b0, psel = 1'b1, pclk = 1'b0;
    logic first = 1'b0;
    logic [31:0] tx_word = 32'h0;
    logic sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic sclk_i, mosi_i, miso_i, sel_n_i, sel_n_o;
    logic tx_pop, rx_valid, rx_close, done, busy, mm_err, tu_ev;
    logic ro_ev, halted;
    logic [23:0] rx_data, got, q;
    logic [7:0] d = 8'h0, r = 8'h0;
    logic [31:0] txq[$];
    logic [23:0] rxq[$];
    int err_count = 0, total_checks = 0, cyc = 0;
    int nchar, sf, fr, lf, sr, dn, gap, nsf, ntu, nro, ncl, n0;

    always #25 core_clk = ~core_clk;

    sts_transfer_seq #(.HALF_DIV(H)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .serial_clock_pin_i(sclk_i), .serial_clock_pin_o(sclk_o),
        .serial_clock_pin_oe_n(sclk_oe_n), .data_out_pin_i(mosi_i),
        .data_out_pin_o(mosi_o), .data_out_pin_oe_n(mosi_oe_n),
        .data_in_pin_i(miso_i), .data_in_pin_o(miso_o),
        .data_in_pin_oe_n(miso_oe_n), .slave_select_n_i(sel_n_i),
        .slave_select_n_o(sel_n_o), .slave_mode(slave_mode),
        .dma_disable(dma_off), .clock_delay_enable(cde),
        .char_len(5'h08), .rx_overflow_mask(ro_m),
        .tx_underflow_mask(tu_m), .master_start_cmd(start),
        .error_clear(clr), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_desc_end(tx_end), .tx_pop(tx_pop), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_fifo_empty(rx_empty), .rx_desc_close(rx_close),
        .master_done_event(done), .master_busy(busy),
        .multi_master_error(mm_err), .tx_underflow_event(tu_ev),
        .rx_overflow_event(ro_ev), .halted(halted)
    );

    sts_peer peer (
        .sclk_o(sclk_o), .mosi_o(mosi_o), .sel_n_o(sel_n_o),
        .miso_o(miso_o), .len(5'h08), .reply({16'h0, r}),
        .sclk_i(sclk_i), .mosi_i(mosi_i), .miso_i(miso_i),
        .sel_n_i(sel_n_i), .got(got), .nchar(nchar)
    );

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // FIFO model and pin timing, sampled before the edge settles
    always @(posedge core_clk) begin
        cyc++;
        if (tx_pop && txq.size() > 0) void'(txq.pop_front());
        if (rx_valid) rxq.push_back(rx_data);
        ncl += int'(rx_close);
        ntu += int'(tu_ev);
        nro += int'(ro_ev);
        if (done) dn = cyc;
        if (psel && !sel_n_o) begin
            sf = cyc;
            first = 1'b1;
            nsf++;
            if (cyc - sr < gap) gap = cyc - sr;
        end
        if (!psel && sel_n_o) sr = cyc;
        if (!pclk && sclk_o && first) begin
            fr = cyc;
            first = 1'b0;
        end
        if (pclk && !sclk_o) lf = cyc;
        psel = sel_n_o;
        pclk = sclk_o;
        if (cyc > 5000) begin
            err_count++;
            give_verdict();
        end
        // Bit 31 of a queued word marks the end of its descriptor
        #2;
        tx_valid = txq.size() > 0;
        tx_end = tx_valid && txq[0][31];
        tx_word = tx_valid ? {1'b0, txq[0][30:0]} : 32'h0;
    end

    task automatic go();
        dn = 0;
        @(posedge core_clk) #2 start = 1'b1;
        @(posedge core_clk) #2 start = 1'b0;
    endtask

    task automatic wait_done(input int lim);
        for (int i = 0; i < lim && dn == 0; i++) @(posedge core_clk);
        #2;
    endtask

    task automatic clear_err();
        @(posedge core_clk) #2 clr = 1'b1;
        @(posedge core_clk) #2 clr = 1'b0;
        @(posedge core_clk) #2;
        chk(32'(halted), 32'h0);
    endtask

    initial begin
        sys_rst = 1'b1;
        void'($urandom(32'h45c6));
        repeat (12) @(posedge core_clk);
        #2 sys_rst = 1'b0;
        repeat (3) @(posedge core_clk);
        #2 chk(32'(sel_n_o), 32'h1);
        chk(32'({sclk_oe_n, miso_oe_n}), 32'h1);
        for (int c = 0; c < 2; c++) begin
            cde = c[0];
            d = 8'($urandom);
            r = 8'($urandom);
            rxq.delete();
            txq.push_back({8'h20, 16'h0, d});
            go();
            wait_done(300);
            chk(fr - sf, H * (c + 1));
            chk(sr - lf, H * (2 - c));
            chk(dn - sr, 1);
            chk(32'(got), 32'(d));
            chk(32'(rxq.size() > 0 ? rxq[0] : 24'h1ff), 32'(r));
            $display("lead trail test %0d over", c);
        end
        cde = 1'b0;
        gap = 999;
        n0 = nsf;
        txq.push_back({8'h10, 16'h0, d});
        txq.push_back({8'h20, 16'h0, r});
        go();
        wait_done(400);
        chk(gap, 3);
        chk(nsf - n0, 2);
        chk(32'(got), 32'(r));
        $display("toggle test over");
        dma_off = 1'b0;
        rx_empty = 1'b0;
        gap = 999;
        n0 = nsf;
        rxq.delete();
        txq.push_back({8'h80, 16'h0, d});
        txq.push_back({8'h80, 16'h0, r});
        go();
        wait_done(400);
        chk(dn, 0);
        chk(32'(gap >= 3), 1);
        chk(nsf - n0, 2);
        chk(rxq.size(), 2);
        chk(32'(busy), 32'h1);
        n0 = cyc;
        rx_empty = 1'b1;
        wait_done(20);
        chk(32'(dn > n0 && dn - n0 <= 3), 1);
        dma_off = 1'b1;
        $display("descriptor test over");
        for (int m = 0; m < 2; m++) begin
            ro_m = m[0];
            rx_ready = 1'b0;
            nro = 0;
            txq.push_back({8'h20, 16'h0, d});
            go();
            wait_done(200);
            chk(nro, 1);
            chk(32'(halted), 32'(!m));
            rx_ready = 1'b1;
            clear_err();
        end
        ntu = 0;
        txq.push_back({8'h00, 16'h0, d});
        go();
        wait_done(200);
        chk(ntu, 1);
        chk(32'({halted, sel_n_o}), 32'h3);
        clear_err();
        // Masked underflow runs on with zeros; reset cuts it short
        tu_m = 1'b1;
        n0 = nchar;
        txq.push_back({8'h00, 16'h0, d});
        go();
        for (int i = 0; i < 300 && nchar - n0 < 2; i++) @(posedge core_clk);
        #2 chk(32'(got), 32'h0);
        chk(32'(halted), 32'h0);
        sys_rst = 1'b1;
        repeat (3) @(posedge core_clk);
        #2 chk(32'(sel_n_o), 32'h1);
        sys_rst = 1'b0;
        tu_m = 1'b0;
        repeat (3) @(posedge core_clk);
        #7 peer.frame(24'h5a, q);
        repeat (4) @(posedge core_clk);
        #2 chk(32'({mm_err, halted}), 32'h3);
        clear_err();
        chk(32'(mm_err), 32'h0);
        $display("error tests over");
        slave_mode = 1'b1;
        repeat (3) @(posedge core_clk);
        #2 chk(32'({sclk_oe_n, mosi_oe_n, miso_oe_n}), 32'h6);
        n0 = ncl;
        txq.push_back({8'h0, 16'h0, d});
        txq.push_back({8'h0, 16'h0, r});
        for (int k = 0; k < 2; k++) begin
            repeat (20) @(posedge core_clk);
            rxq.delete();
            #7 peer.frame({16'h0, ~d}, q);
            repeat (20) @(posedge core_clk);
            chk(32'(q), k ? 32'(r) : 32'(d));
            chk(32'(rxq.size() > 0 ? rxq[0] : 24'h1ff), {24'h0, ~d});
            chk(ncl - n0, k + 1);
        end
        $display("slave test over");
        give_verdict();
    end
endmodule
